// >>> pss_burst.sv
`timescale 1ns/10ps
`default_nettype none
module pss_burst (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_rstn,
	input  wire logic                        i_load,
	input  wire logic                        i_advance,
	input  wire logic [pss_pkg::BURST_W-1:0] i_start,
	input  wire logic                        i_interleave,
	output logic      [pss_pkg::BURST_W-1:0] o_low
);
	import pss_pkg::*;

	logic [BURST_W-1:0] start;
	logic [BURST_W-1:0] beat;
	logic [BURST_W-1:0] next_beat;

	assign next_beat = BURST_W'(beat + 2'h1); // wraps modulo four

	// start value and beat index; a load wins over an advance
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			start <= '0;
			beat  <= '0;
			o_low <= '0;
		end else if (i_load) begin
			start <= i_start;
			beat  <= '0;
			o_low <= i_start;
		end else if (i_advance) begin
			beat  <= next_beat;
			o_low <= pss_burst_addr(start, next_beat, i_interleave);
		end
	end
endmodule
`default_nettype wire

// >>> pss_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module pss_ctl (
	input  wire logic                  i_ref_clk,
	output logic                       o_rstn,
	output logic                       o_qual_n,
	output logic [2:0]                 o_sel,
	output logic                       o_bnl,
	output logic                       o_wr_n,
	output logic [pss_pkg::LANES-1:0]  o_mask_n,
	output logic                       o_oe_n,
	output logic [pss_pkg::ADDR_W-1:0] o_addr,
	output logic [pss_pkg::DATA_W-1:0] o_dq,
	output logic                       o_order,
	output logic                       o_sleep,
	output logic                       o_shut
);
	import pss_pkg::*;

	// ----------------------------------------
	// controller side of the command port
	// ----------------------------------------
	// known levels before the first edge
	// reset, shutdown and strap pins belong to rst, which runs at time zero
	initial begin
		o_qual_n = 1'b0;
		o_sleep = 1'b0;
	end

	// one bus cycle; pins move just after the edge
	task automatic cyc(input logic b, input logic [2:0] s, input logic w,
			input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m,
			input logic [DATA_W-1:0] d, input logic o);
		@(posedge i_ref_clk);
		#1;
		o_qual_n = 1'b0;
		o_bnl = b;
		o_sel = s;
		o_wr_n = w;
		o_addr = a;
		o_mask_n = m;
		o_oe_n = o;
		o_dq = d;
	endtask

	// deselect cycle: one select off, load low
	task automatic idle();
		cyc(1'b0, 3'b110, 1'b1, '0, '0, '0, 1'b0);
	endtask

	// hold the previous cycle for one edge
	task automatic stall();
		@(posedge i_ref_clk);
		#1;
		o_qual_n = 1'b1;
	endtask

	// pipeline must drain while deselected on both sides of sleep
	task automatic nap(input logic on);
		if (on) begin
			repeat (2) idle();
			o_sleep = 1'b1;
		end else begin
			o_sleep = 1'b0;
			repeat (2) idle();
		end
	endtask

	// deep power-down, only a reset brings it back
	task automatic down();
		o_shut = 1'b1;
	endtask

	// reset pulse, strap set while reset is low
	task automatic rst(input logic ord);
		o_rstn = 1'b0;
		o_shut = 1'b0;
		o_order = ord;
		repeat (5) idle();
		o_rstn = 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> pss_mem.sv
`timescale 1ns/10ps
`default_nettype none
module pss_mem #(
	parameter int DATA_W = pss_pkg::DATA_W,
	parameter int ADDR_W = pss_pkg::ADDR_W,
	parameter int LANES  = pss_pkg::LANES
) (
	input  wire logic              i_ref_clk,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic              i_we,
	input  wire logic [LANES-1:0]  i_lane_en,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_re,
	output logic      [DATA_W-1:0] o_rdata
);
	import pss_pkg::*;

	localparam int LW = DATA_W / LANES;

	logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

	// lane-masked write, masked lanes keep old bytes
	always_ff @(posedge i_ref_clk) begin
		if (i_we) begin
			for (int i = 0; i < LANES; i++) begin
				if (i_lane_en[i]) begin
					store[i_addr][i*LW +: LW] <= i_wdata[i*LW +: LW];
				end
			end
		end
	end

	// read data held in a register until the next read
	always_ff @(posedge i_ref_clk) begin
		if (i_re) begin
			o_rdata <= store[i_addr];
		end
	end
endmodule
`default_nettype wire

// >>> pss_pkg.sv
`default_nettype none
package pss_pkg;
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int DATA_W  = 48;
	localparam int ADDR_W  = 21;
	localparam int LANES   = 6;
	localparam int LANE_W  = 8;
	localparam int BURST_W = 2;

	// ----------------------------------------
	// timing, clock at 250 MHz
	// ----------------------------------------
	localparam int CLK_MHZ            = 250;
	localparam int T_CQV_NS           = 7;
	localparam int CLK_NS             = 4;
	localparam int CQV_CYCLES         = (T_CQV_NS / CLK_NS < 1) ? 1 : T_CQV_NS / CLK_NS;
	localparam int T_RESET_COMPLETE_US = 50;
	localparam int T_CLOCK_SYNC_US    = 20;
	localparam int RESET_CYCLES       = T_RESET_COMPLETE_US * CLK_MHZ;
	localparam int SYNC_CYCLES        = T_CLOCK_SYNC_US * CLK_MHZ;
	localparam int TIMER_W            = 16;
	localparam int HK_INTERVAL        = 1024;
	localparam int HK_GRACE           = 16;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [LANES-1:0] LANE_MASK_RST = 6'h3F;
	localparam logic [TIMER_W-1:0] TIMER_RST   = 16'h0000;

	// ----------------------------------------
	// device state, gray along init-sync-run
	// ----------------------------------------
	typedef enum logic [1:0] {
		PSS_INIT = 2'h0,
		PSS_SYNC = 2'h1,
		PSS_RUN  = 2'h3,
		PSS_SHUT = 2'h2
	} pss_state_type;

	// low address bits of a burst beat
	function automatic logic [BURST_W-1:0] pss_burst_addr(
		input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] beat,
		input logic               interleave
	);
		pss_burst_addr = interleave ? (start ^ beat) : BURST_W'(start + beat);
	endfunction
endpackage
`default_nettype wire

// >>> pss_port.sv
`timescale 1ns/10ps
`default_nettype none
module pss_port #(
	parameter int ADDR_W       = pss_pkg::ADDR_W,
	parameter int RESET_CYCLES = pss_pkg::RESET_CYCLES,
	parameter int SYNC_CYCLES  = pss_pkg::SYNC_CYCLES,
	parameter int HK_INTERVAL  = pss_pkg::HK_INTERVAL,
	parameter int HK_GRACE     = pss_pkg::HK_GRACE
) (
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rstn,
	input  wire logic                       i_clk_qualify_n,
	input  wire logic                       i_select_a_n,
	input  wire logic                       i_select_b,
	input  wire logic                       i_select_c_n,
	input  wire logic                       i_burst_next_or_load,
	input  wire logic                       i_write_n,
	input  wire logic [pss_pkg::LANES-1:0]  i_lane_mask_n,
	input  wire logic                       i_out_enable_n,
	input  wire logic [ADDR_W-1:0]          i_addr,
	input  wire logic [pss_pkg::DATA_W-1:0] i_dq_in,
	output logic      [pss_pkg::DATA_W-1:0] o_dq_out,
	output logic                            o_dq_oe,
	input  wire logic                       i_burst_order,
	input  wire logic                       i_sleep_req,
	input  wire logic                       i_shutdown,
	output logic                            o_ready,
	output logic                            o_asleep
);
	import pss_pkg::*;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	pss_state_type      state;
	logic [TIMER_W-1:0] timer;
	logic               qual;
	logic               load;
	logic               sel_all;
	logic               start_op;
	logic               cont;
	logic               idle;
	logic               act;
	logic               wr;
	logic [ADDR_W-1:0]  addr_q;
	logic [LANES-1:0]   lane_q;
	logic [BURST_W-1:0] low;
	logic               interleave;
	logic               strap_taken;
	logic               drive_q;
	logic               mem_we;
	logic               mem_re;
	logic [ADDR_W-1:0]  mem_addr;
	logic [LANES-1:0]   mem_lane_en;

	// stalled, asleep or not yet running edges do nothing
	assign qual     = !i_clk_qualify_n && state == PSS_RUN && !i_sleep_req
	                  && !i_shutdown;
	assign load     = !i_burst_next_or_load;
	assign sel_all  = !i_select_a_n && i_select_b && !i_select_c_n;
	assign start_op = qual && load && sel_all;
	assign cont     = qual && !load;
	assign idle     = qual && !(load ? sel_all : act);

	// ----------------------------------------
	// burst order strap
	// ----------------------------------------
	// caught by a clocked process just after reset release
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			strap_taken <= 1'b0;
			interleave  <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			interleave  <= i_burst_order;
		end
	end

	// ----------------------------------------
	// address and command stage
	// ----------------------------------------
	// a deselect clears act; continue beats keep the latched command
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || state != PSS_RUN) begin
			act    <= 1'b0;
			wr     <= 1'b0;
			addr_q <= '0;
			lane_q <= LANE_MASK_RST;
		end else if (qual) begin
			if (load) begin
				act    <= sel_all;
				wr     <= sel_all && !i_write_n;
				addr_q <= i_addr;
				lane_q <= i_write_n ? LANE_MASK_RST : i_lane_mask_n;
			end else begin
				lane_q <= i_lane_mask_n;
			end
		end
	end

	// low bits come from the counter once the address is loaded
	pss_burst u_burst (
		.i_ref_clk    (i_ref_clk),
		.i_rstn       (i_rstn),
		.i_load       (qual && load),
		.i_advance    (cont),
		.i_start      (i_addr[BURST_W-1:0]),
		.i_interleave (interleave),
		.o_low        (low)
	);

	// ----------------------------------------
	// memory access, one edge after capture
	// ----------------------------------------
	assign mem_addr    = {addr_q[ADDR_W-1:BURST_W], low};
	assign mem_we      = qual && act && wr;
	assign mem_re      = qual && act && !wr;
	assign mem_lane_en = mem_we ? ~lane_q : '0;

	// contents survive sleep since the array has no reset
	pss_mem #(
		.DATA_W (DATA_W),
		.ADDR_W (ADDR_W),
		.LANES  (LANES)
	) u_mem (
		.i_ref_clk (i_ref_clk),
		.i_addr    (mem_addr),
		.i_we      (mem_we),
		.i_lane_en (mem_lane_en),
		.i_wdata   (i_dq_in),
		.i_re      (mem_re),
		.o_rdata   (o_dq_out)
	);

	// ----------------------------------------
	// output drivers
	// ----------------------------------------
	// pipelined: drive follows the stage that was captured one edge ago
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || state != PSS_RUN || i_sleep_req || i_shutdown) begin
			drive_q <= 1'b0;
		end else if (qual) begin
			drive_q <= act && !wr;
		end
	end

	// output enable is combinational, so no clock is needed to release
	assign o_dq_oe = drive_q && !i_out_enable_n;

	// ----------------------------------------
	// reset, clock sync and shutdown sequence
	// ----------------------------------------
	// shutdown is left only through reset, so contents count as lost
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			state <= PSS_INIT;
			timer <= TIMER_RST;
		end else if (i_shutdown) begin
			state <= PSS_SHUT;
			timer <= TIMER_RST;
		end else begin
			case (state)
				PSS_INIT: begin
					if (timer == TIMER_W'(RESET_CYCLES - 1)) begin
						state <= PSS_SYNC;
						timer <= TIMER_RST;
					end else begin
						timer <= TIMER_W'(timer + 16'h0001);
					end
				end
				PSS_SYNC: begin
					if (timer == TIMER_W'(SYNC_CYCLES - 1)) begin
						state <= PSS_RUN;
						timer <= TIMER_RST;
					end else begin
						timer <= TIMER_W'(timer + 16'h0001);
					end
				end
				PSS_RUN: begin
					state <= PSS_RUN;
				end
				PSS_SHUT: begin
					state <= PSS_SHUT;
				end
				default: begin
					state <= PSS_INIT;
					timer <= TIMER_RST;
				end
			endcase
		end
	end

	// ----------------------------------------
	// background housekeeping and ready
	// ----------------------------------------
	logic [TIMER_W-1:0] hk_timer;
	logic [TIMER_W-1:0] hk_wait;
	logic               hk_due;
	logic               hk_overdue;

	assign hk_overdue = hk_due && hk_wait == TIMER_W'(HK_GRACE);

	// a new due event beats an idle cycle in the same edge
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || state != PSS_RUN) begin
			hk_timer <= TIMER_RST;
			hk_wait  <= TIMER_RST;
			hk_due   <= 1'b0;
		end else begin
			if (hk_timer == TIMER_W'(HK_INTERVAL - 1)) begin
				hk_timer <= TIMER_RST;
				hk_due   <= 1'b1;
			end else begin
				hk_timer <= TIMER_W'(hk_timer + 16'h0001);
				if (idle || i_sleep_req) begin
					hk_due <= 1'b0;
				end
			end
			if (!hk_due || idle) begin
				hk_wait <= TIMER_RST;
			end else if (!hk_overdue) begin
				hk_wait <= TIMER_W'(hk_wait + 16'h0001);
			end
		end
	end

	// ready rises one edge after the sync interval ends
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_ready  <= 1'b0;
			o_asleep <= 1'b0;
		end else begin
			o_ready  <= state == PSS_RUN && !i_shutdown && !hk_overdue;
			o_asleep <= state == PSS_RUN && i_sleep_req;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	logic start_rd;
	logic start_wr;
	assign start_rd = start_op && i_write_n;
	assign start_wr = start_op && !i_write_n;

	chk_read_latency: assert property (
		start_rd ##1 qual |=> drive_q && (o_dq_oe == !i_out_enable_n)
	) else $error("read data not driven one clock after capture");

	chk_back_to_back: assert property (
		start_rd ##1 (start_op && !i_write_n) |=> act && wr
	) else $error("write right after read was not accepted");

	chk_deselect_off: assert property (
		(qual && load && !sel_all) ##1 qual |=> !o_dq_oe
	) else $error("outputs still driven after deselect");

	chk_write_tristate: assert property (
		start_wr ##1 qual |=> !o_dq_oe && !drive_q
	) else $error("outputs driven in write data cycle");

	chk_linear_step: assert property (
		(cont && !interleave) |=> low == BURST_W'($past(low) + 2'h1)
	) else $error("linear burst did not step by one");

	chk_interleave_step: assert property (
		(cont && interleave) |=> ((low ^ $past(low)) == 2'h1)
		                         || ((low ^ $past(low)) == 2'h3)
	) else $error("interleaved burst step is wrong");

	chk_burst_latched: assert property (
		(cont && act) |=> act && (wr == $past(wr))
	) else $error("burst lost its read or write choice");

	chk_read_no_lanes: assert property (
		start_rd |=> lane_q == LANE_MASK_RST && !mem_we
	) else $error("lanes armed during a read");

	chk_lane_capture: assert property (
		start_wr |=> lane_q == $past(i_lane_mask_n)
	) else $error("write lane masks not captured with the command");

	chk_stall_hold: assert property (
		(state == PSS_RUN && i_clk_qualify_n) |=> $stable(act) && $stable(wr)
		                                          && $stable(low) && $stable(drive_q)
	) else $error("state moved during a stall");

	chk_ready_order: assert property (
		$rose(state == PSS_RUN) |-> $past(state) == PSS_SYNC ##1 o_ready || hk_overdue
		                            || i_shutdown
	) else $error("ready did not follow the sync interval");

	chk_idle_quiet: assert property (
		state != PSS_RUN |-> ##1 !o_dq_oe && !o_ready
	) else $error("driving or ready before normal operation");

	// the strap is read once; a later change must not reorder bursts
	chk_strap_fixed: assert property (
		strap_taken |=> $stable(interleave)
	) else $error("burst order changed after power-up");

	chk_shut_quiet: assert property (
		i_shutdown |=> !drive_q && !o_ready && !o_dq_oe
	) else $error("driving or ready during shutdown");

	cov_read_burst: cover property (
		start_rd ##1 cont ##1 cont ##1 cont ##1 qual
	);
	cov_write_start: cover property (start_wr ##1 qual);
	cov_stall_read: cover property (start_rd ##1 i_clk_qualify_n ##1 qual);
	cov_ready_rise: cover property ($rose(o_ready));
	cov_back_to_back: cover property (start_rd ##1 start_wr);
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import pss_pkg::*;
	localparam int RC = 4;
	localparam int SC = 3;
	localparam logic [2:0] ON = 3'b010;
	localparam logic [2:0] OFF = 3'b110;
	localparam logic [ADDR_W-1:0] BASE = 21'h0A_BC01;
	typedef struct packed {
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [LANES-1:0]  m;
		logic [DATA_W-1:0] x;
	} pss_row_type;

	logic              clk;
	logic              rstn, qn, bnl, wrn, oen, ord, slp, sht;
	logic              dq_oe, ready, asleep, lo;
	logic [2:0]        sel;
	logic [LANES-1:0]  mk;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] dq, dq_bus, dq_out;
	int                err_total, checks_done;

	// ----------------------------------------
	// write then read back, masked lanes keep old bytes
	// ----------------------------------------
	pss_row_type rows [5] = '{
		'{21'h0_0010, 48'h1111_2222_3333, 6'h00, 48'h1111_2222_3333},
		'{21'h0_0010, 48'hAAAA_BBBB_CCCC, 6'h15, 48'hAA11_BB22_CC33},
		'{21'h0_0010, 48'hFFFF_FFFF_FFFF, 6'h3F, 48'hAA11_BB22_CC33},
		'{21'h1F_FFFF, 48'h0123_4567_89AB, 6'h00, 48'h0123_4567_89AB},
		'{21'h1F_FFFF, 48'hFEDC_BA98_7654, 6'h3E, 48'h0123_4567_8954}
	};

	// released bus carries dq while oen is high and the inverse of dq while oen is low
	assign dq_bus = dq_oe ? dq_out : (oen ? dq : ~dq);

	pss_ctl u_ctl (
		.i_ref_clk(clk), .o_rstn(rstn), .o_qual_n(qn), .o_sel(sel),
		.o_bnl(bnl), .o_wr_n(wrn), .o_mask_n(mk), .o_oe_n(oen),
		.o_addr(addr), .o_dq(dq), .o_order(ord), .o_sleep(slp), .o_shut(sht)
	);

	pss_port #(.RESET_CYCLES(RC), .SYNC_CYCLES(SC), .HK_INTERVAL(64), .HK_GRACE(4)) u_dut (
		.i_ref_clk(clk), .i_rstn(rstn), .i_clk_qualify_n(qn),
		.i_select_a_n(sel[2]), .i_select_b(sel[1]), .i_select_c_n(sel[0]),
		.i_burst_next_or_load(bnl), .i_write_n(wrn), .i_lane_mask_n(mk),
		.i_out_enable_n(oen), .i_addr(addr), .i_dq_in(dq_bus), .o_dq_out(dq_out),
		.o_dq_oe(dq_oe), .i_burst_order(ord), .i_sleep_req(slp), .i_shutdown(sht),
		.o_ready(ready), .o_asleep(asleep)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] x);
		checks_done++;
		if (s !== x) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
			input logic [LANES-1:0] m);
		u_ctl.cyc(1'b0, ON, 1'b0, a, m, '0, 1'b0);
		u_ctl.cyc(1'b0, OFF, 1'b1, '0, '0, d, 1'b1);
	endtask

	// data lands one edge after the capture edge
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
		u_ctl.cyc(1'b0, ON, 1'b1, a, '0, '0, 1'b0);
		u_ctl.idle();
		u_ctl.idle();
		chk("rdata", dq_out, x);
		chk("rd_oe", DATA_W'(dq_oe), DATA_W'(1'b1));
	endtask

	function automatic logic [DATA_W-1:0] bd(input int k, input logic il);
		bd = 48'hC0DE_5A5A_0000 + DATA_W'(k) + (il ? 48'h0000_0000_0100 : '0);
	endfunction

	function automatic logic [ADDR_W-1:0] ea(input int k, input logic il);
		ea = {BASE[ADDR_W-1:2], il ? (2'b01 ^ 2'(k)) : 2'(2'b01 + 2'(k))};
	endfunction

	// ready must stay low through reset completion and clock sync
	task automatic boot(input logic il);
		int n;
		n = 0;
		u_ctl.rst(il);
		chk("rst_oe", DATA_W'(dq_oe), DATA_W'(1'b0));
		chk("rst_ready", DATA_W'(ready), DATA_W'(1'b0));
		while (ready !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		// ready rises one edge after run is entered
		chk("ready_time", DATA_W'(n), DATA_W'(RC + SC + 1));
	endtask

	// burst write with ignored selects, single reads, then burst read with a stall
	task automatic bst(input logic il);
		for (int i = 0; i < 5; i++) begin
			u_ctl.cyc(i > 0 && i < 4, i == 0 ? ON : 3'b000, i != 0, BASE, '0, bd(i - 1, il), i > 0);
		end
		for (int k = 0; k < 4; k++) begin
			rd(ea(k, il), bd(k, il));
		end
		u_ctl.cyc(1'b0, ON, 1'b1, BASE, '0, '0, 1'b0);
		u_ctl.cyc(1'b1, 3'b011, 1'b0, '0, '0, '0, 1'b0);
		u_ctl.cyc(1'b1, 3'b011, 1'b0, '0, '0, '0, 1'b0);
		chk("beat0", dq_out, bd(0, il));
		u_ctl.stall();
		chk("beat1", dq_out, bd(1, il));
		u_ctl.cyc(1'b1, 3'b011, 1'b0, '0, '0, '0, 1'b0);
		chk("stalled", dq_out, bd(1, il));
		u_ctl.idle();
		chk("beat2", dq_out, bd(2, il));
		u_ctl.idle();
		chk("beat3", dq_out, bd(3, il));
		chk("oe_held", DATA_W'(dq_oe), DATA_W'(1'b1));
		u_ctl.idle();
		chk("oe_off", DATA_W'(dq_oe), DATA_W'(1'b0));
	endtask

	// ----------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#20000;
		err_total++;
		wrap_up();
	end

	initial begin
		err_total = 0;
		checks_done = 0;
		boot(1'b0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].m);
			rd(rows[i].a, rows[i].x);
		end
		// write right behind a read; read data stands while the write data is on the bus
		u_ctl.cyc(1'b0, ON, 1'b1, rows[4].a, '0, '0, 1'b0);
		u_ctl.cyc(1'b0, ON, 1'b0, 21'h0_0030, '0, '0, 1'b1);
		u_ctl.cyc(1'b0, OFF, 1'b1, '0, '0, 48'h5555_6666_7777, 1'b1);
		chk("rd_then_wr", dq_out, rows[4].x);
		rd(21'h0_0030, 48'h5555_6666_7777);
		bst(1'b0);
		// unbroken read stream starves housekeeping
		lo = 1'b0;
		for (int i = 0; i < 90; i++) begin
			u_ctl.cyc(i != 0, ON, 1'b1, '0, '0, '0, 1'b0);
			if (ready !== 1'b1) lo = 1'b1;
		end
		chk("ready_drop", DATA_W'(lo), DATA_W'(1'b1));
		repeat (3) u_ctl.idle();
		chk("ready_back", DATA_W'(ready), DATA_W'(1'b1));
		// disabled output enable keeps the pins quiet on a read
		u_ctl.cyc(1'b0, ON, 1'b1, rows[0].a, '0, '0, 1'b1);
		u_ctl.cyc(1'b0, OFF, 1'b1, '0, '0, '0, 1'b1);
		u_ctl.cyc(1'b0, OFF, 1'b1, '0, '0, '0, 1'b1);
		chk("oe_masked", DATA_W'(dq_oe), DATA_W'(1'b0));
		chk("rdata_hidden", dq_out, rows[2].x);
		u_ctl.nap(1'b1);
		repeat (2) u_ctl.idle();
		chk("asleep", DATA_W'(asleep), DATA_W'(1'b1));
		u_ctl.nap(1'b0);
		rd(rows[4].a, rows[4].x);
		u_ctl.down();
		repeat (2) u_ctl.idle();
		chk("shut_ready", DATA_W'(ready), DATA_W'(1'b0));
		chk("shut_oe", DATA_W'(dq_oe), DATA_W'(1'b0));
		boot(1'b1);
		bst(1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
